// file: rst_wdt_pkg.sv
// Constants and types shared by the reset and watchdog block
package rst_wdt_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STAT_ADDR = 4'h4;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int UNLOCK_BIT = 4;
	localparam int ENABLE_BIT = 3;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam int FLAG_BIT = 3;
	localparam int INRESET_BIT = 0;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic FLAG_RST = 1'b0;
	// ----------------------------------------
	// Timing, counter width and bus response codes
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DROP_FILTER_NS = 2000;
	localparam int DROP_FILTER_CYC =
		(DROP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] UNLOCK_CYC = 3'h4;
	localparam int WD_OSC_KHZ = 1000;
	localparam int MIN_PERIOD_LOG2 = 14;
	localparam int WDCNT_W = 21;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Reset sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		RST_HOLD = 2'b00,
		RST_STRETCH = 2'b01,
		RST_RUN = 2'b10
	} rst_state_e;
endpackage : rst_wdt_pkg

// file: reset_sources_and_watchdog.sv
// Reset source combiner, start-up stretch and watchdog with AXI4-Lite regs
`timescale 1ns/1ns
module reset_sources_and_watchdog (
	// Clock and bus reset
	input wire logic clk,
	input wire logic rstn,
	// AXI4-Lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Detectors, pin and fuses
	input wire logic supplyLow,
	input wire logic extResetN,
	input wire logic dropLow,
	input wire logic [2:0] supplyTripLevelFuse,
	input wire logic alwaysOnFuse,
	input wire logic [15:0] startupDelay,
	// Reference enable conditions
	input wire logic comparatorBandgapSelect,
	input wire logic adcEnable,
	// Watchdog oscillator and kick
	input wire logic wdOscTick,
	input wire logic kick,
	// Results
	output logic chipResetN,
	output logic refEnable,
	output logic dogResetPulse
);
	import rst_wdt_pkg::*;

	// ----------------------------------------
	// Supply-drop filter
	// ----------------------------------------
	// All-ones fuse code means detector off
	logic dropEnabled;
	assign dropEnabled = supplyTripLevelFuse != 3'h7;
	logic [15:0] dropCnt_ff;
	logic dropTrip_ff;
	always_ff @(posedge clk) begin
		if (!rstn || !dropEnabled || !dropLow) begin
			dropCnt_ff <= 16'h0000;
			dropTrip_ff <= 1'b0;
		end else if (dropCnt_ff < 16'(DROP_FILTER_CYC)) begin
			dropCnt_ff <= dropCnt_ff + 16'h0001;
		end else begin
			dropTrip_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	logic srcActive;
	// Pin sampled on clk: a dead clock cannot catch it
	assign srcActive = supplyLow || !extResetN || dropTrip_ff
		|| dogResetPulse;
	rst_state_e state_ff;
	logic [15:0] stretch_ff;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= RST_HOLD;
			stretch_ff <= 16'h0000;
			chipResetN <= 1'b0;
		end else if (srcActive) begin
			state_ff <= RST_HOLD;
			stretch_ff <= 16'h0000;
			chipResetN <= 1'b0;
		end else begin
			case (state_ff)
				RST_HOLD: begin
					state_ff <= RST_STRETCH;
					stretch_ff <= 16'h0000;
				end
				RST_STRETCH: begin
					if (stretch_ff >= startupDelay) begin
						state_ff <= RST_RUN;
						chipResetN <= 1'b1;
					end else begin
						stretch_ff <= stretch_ff + 16'h0001;
					end
				end
				RST_RUN: chipResetN <= 1'b1;
				default: state_ff <= RST_HOLD;
			endcase
		end
	end

	// ----------------------------------------
	// Voltage reference
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			refEnable <= 1'b0;
		end else begin
			refEnable <= dropEnabled || comparatorBandgapSelect
				|| adcEnable;
		end
	end

	// ----------------------------------------
	// Bus write channel
	// ----------------------------------------
	logic [3:0] wAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic doWrite;
	assign doWrite = !awready && !wready && !bvalid;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			wAddr_ff <= 4'h0;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wAddr_ff <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp <= (wAddr_ff == CTRL_ADDR || wAddr_ff == STAT_ADDR)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end
	logic ctrlWr;
	logic statWr;
	assign ctrlWr = doWrite && wAddr_ff == CTRL_ADDR && wStrb_ff[0];
	assign statWr = doWrite && wAddr_ff == STAT_ADDR && wStrb_ff[0];
	logic wUnlock;
	logic wEnable;
	logic [2:0] wSel;
	assign wUnlock = wData_ff[UNLOCK_BIT];
	assign wEnable = wData_ff[ENABLE_BIT];
	assign wSel = wData_ff[SEL_LSB +: SEL_W];

	// ----------------------------------------
	// Watchdog control
	// ----------------------------------------
	logic level2;
	assign level2 = alwaysOnFuse;
	logic [2:0] unlockCnt_ff;
	logic unlockOpen;
	assign unlockOpen = unlockCnt_ff != 3'h0;
	logic dogEnable_ff;
	logic [2:0] timeoutSelect_ff;
	always_ff @(posedge clk) begin
		if (!rstn || !chipResetN) begin
			unlockCnt_ff <= 3'h0;
		end else if (ctrlWr && wUnlock && wEnable) begin
			unlockCnt_ff <= UNLOCK_CYC;
		end else if (unlockOpen) begin
			unlockCnt_ff <= unlockCnt_ff - 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn || !chipResetN) begin
			dogEnable_ff <= level2;
			timeoutSelect_ff <= SEL_RST;
		end else if (level2) begin
			dogEnable_ff <= 1'b1;
			if (ctrlWr && !wUnlock && unlockOpen) begin
				timeoutSelect_ff <= wSel;
			end
		end else if (ctrlWr) begin
			if (!wUnlock && unlockOpen) begin
				dogEnable_ff <= wEnable;
				timeoutSelect_ff <= wSel;
			end else if (wEnable) begin
				dogEnable_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Watchdog counter
	// ----------------------------------------
	// Oscillator edges arrive as clk-synchronous ticks
	logic [WDCNT_W-1:0] wdCnt_ff;
	logic [WDCNT_W-1:0] wdLast;
	assign wdLast = WDCNT_W'((22'h1 << (MIN_PERIOD_LOG2
		+ int'(timeoutSelect_ff))) - 22'h1);
	logic wdExpire;
	assign wdExpire = dogEnable_ff && wdOscTick && wdCnt_ff == wdLast;
	always_ff @(posedge clk) begin
		if (!rstn || !chipResetN || kick || !dogEnable_ff) begin
			wdCnt_ff <= '0;
		end else if (wdOscTick) begin
			wdCnt_ff <= wdCnt_ff + WDCNT_W'(1);
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dogResetPulse <= 1'b0;
		end else begin
			dogResetPulse <= wdExpire && chipResetN;
		end
	end

	// ----------------------------------------
	// Reset flag
	// ----------------------------------------
	logic dogResetFlag_ff;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dogResetFlag_ff <= FLAG_RST;
		end else if (dogResetPulse) begin
			dogResetFlag_ff <= 1'b1;
		end else if (supplyLow || (statWr && !wData_ff[FLAG_BIT])) begin
			dogResetFlag_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Bus read channel
	// ----------------------------------------
	logic [31:0] ctrlView;
	logic [31:0] statView;
	always_comb begin
		ctrlView = 32'h00000000;
		ctrlView[UNLOCK_BIT] = unlockOpen;
		ctrlView[ENABLE_BIT] = dogEnable_ff || level2;
		ctrlView[SEL_LSB +: SEL_W] = timeoutSelect_ff;
		statView = 32'h00000000;
		statView[FLAG_BIT] = dogResetFlag_ff;
		statView[INRESET_BIT] = !chipResetN;
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			if (araddr == CTRL_ADDR) begin
				rdata <= ctrlView;
			end else if (araddr == STAT_ADDR) begin
				rdata <= statView;
			end else begin
				rdata <= 32'h00000000;
				rresp <= RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Own run length of the drop input, kept apart from the filter
	logic [15:0] lowRun_ff;
	always_ff @(posedge clk) begin
		if (!rstn || !dropLow) begin
			lowRun_ff <= 16'h0000;
		end else if (lowRun_ff != 16'hFFFF) begin
			lowRun_ff <= lowRun_ff + 16'h0001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_supply_hold: assert property (
		supplyLow |=> !chipResetN)
		else $error("reset not held while supply low");
	a_supply_drop: assert property (
		chipResetN && supplyLow |=> !chipResetN && state_ff == RST_HOLD)
		else $error("supply loss not immediate");
	a_pin_reset: assert property (
		!extResetN |=> !chipResetN)
		else $error("pin low did not reset");
	a_pin_stretch: assert property (
		$rose(extResetN) && !supplyLow && !dropTrip_ff && !dogResetPulse
		|=> !chipResetN)
		else $error("release without stretch");
	a_drop_filter: assert property (
		$rose(dropTrip_ff) |-> $past(dropLow)
		&& lowRun_ff >= 16'(DROP_FILTER_CYC))
		else $error("drop tripped before filter time");
	a_dog_pulse: assert property (
		dogResetPulse |=> !dogResetPulse && !chipResetN)
		else $error("dog pulse not one cycle");
	a_ref_on: assert property (
		(comparatorBandgapSelect || adcEnable) |=> refEnable)
		else $error("reference not enabled");
	a_kick_clear: assert property (
		kick |=> wdCnt_ff == '0)
		else $error("kick did not clear counter");
	a_cnt_clear: assert property (
		(!chipResetN || !dogEnable_ff) |=> wdCnt_ff == '0)
		else $error("counter not cleared");
	a_unlock_close: assert property (
		$rose(unlockOpen) |-> ##4 !unlockOpen)
		else $error("unlock window not four cycles");
	a_level2_on: assert property (
		level2 && chipResetN |=> dogEnable_ff)
		else $error("level two watchdog off");
	a_no_clear: assert property (
		dogEnable_ff && !unlockOpen && chipResetN |=> dogEnable_ff)
		else $error("enable cleared without unlock");
	a_flag_set: assert property (
		dogResetPulse |=> dogResetFlag_ff)
		else $error("flag not set by dog reset");

	c_dog_fire: cover property (dogResetPulse);
	c_unlock_write: cover property (unlockOpen && ctrlWr && !wUnlock);
	c_release: cover property ($rose(chipResetN));
	c_drop_trip: cover property ($rose(dropTrip_ff));
endmodule : reset_sources_and_watchdog

// file: supply_partner.sv
// Model of the supply detectors, reset pin and watchdog oscillator
`timescale 1ns/1ns
module supply_partner (
	// Control from the bench
	input wire logic clk,
	input wire logic tickOn,
	input wire logic go,
	input wire logic [1:0] which,
	input wire logic [11:0] len,
	// Far side levels
	output logic wdOscTick,
	output logic supplyLow,
	output logic dropLow,
	output logic extResetN
);
	logic [11:0] cnt_ff = 12'h000;
	logic [1:0] src_ff = 2'h0;
	logic active;
	always_ff @(posedge clk) begin
		if (go) begin
			cnt_ff <= len;
			src_ff <= which;
		end else if (active) begin
			cnt_ff <= cnt_ff - 12'h001;
		end
	end
	// One source at a time, held for len cycles
	assign active = cnt_ff != 12'h000;
	assign supplyLow = active && src_ff == 2'h0;
	assign dropLow = active && src_ff == 2'h1;
	assign extResetN = !(active && src_ff == 2'h2);
	// Fastest oscillator: one tick per clock
	assign wdOscTick = tickOn;
endmodule : supply_partner

// file: reset_sources_and_watchdog_test.sv
// Self-checking bench for the reset sources and watchdog block
`timescale 1ns/1ns
module reset_sources_and_watchdog_test;
	import rst_wdt_pkg::*;
	logic [15:0] dly;
	logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, kick;
	logic awready, wready, bvalid, arready, rvalid, bandgap, adcEn;
	logic supplyLow, extResetN, dropLow, alwaysOnFuse, wdOscTick, tickOn;
	logic go, chipResetN, refEnable, dogResetPulse;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, which, rsp, bsp;
	logic [2:0] fuse;
	logic [11:0] len;
	int err_count = 0, checks = 0, cyc = 0, dogCnt = 0, n, m, mSel;

	reset_sources_and_watchdog u_dut (.clk(clk), .rstn(rstn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.supplyLow(supplyLow), .extResetN(extResetN), .dropLow(dropLow),
		.supplyTripLevelFuse(fuse), .alwaysOnFuse(alwaysOnFuse),
		.startupDelay(dly), .comparatorBandgapSelect(bandgap),
		.adcEnable(adcEn), .wdOscTick(wdOscTick), .kick(kick),
		.chipResetN(chipResetN), .refEnable(refEnable),
		.dogResetPulse(dogResetPulse));
	supply_partner u_far (.clk(clk), .tickOn(tickOn), .go(go),
		.which(which), .len(len), .wdOscTick(wdOscTick),
		.supplyLow(supplyLow), .dropLow(dropLow), .extResetN(extResetN));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (dogResetPulse === 1'b1) dogCnt++;
		if (cyc == 90000) begin
			err_count++;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (exp !== got) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bsp = bresp;
		bready <= 1'b0;
	endtask : wr

	task rdt(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : rdt

	task ctl(input logic [31:0] exp);
		repeat (6) @(posedge clk);
		rdt(CTRL_ADDR);
		chk("ctrl", exp, rd);
	endtask : ctl

	// Waits for release; with c set, the stretch length is judged
	task relWait(input bit c);
		do @(posedge clk); while (supplyLow || dropLow || !extResetN);
		n = 0;
		while (chipResetN !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (c) begin
			m = (n >= dly + 1 && n <= dly + 3) ? dly + 2 : n;
			chk("stretch", dly + 2, m);
		end
	endtask : relWait

	task srcHit(input logic [1:0] w, input logic [11:0] l);
		@(posedge clk);
		which <= w;
		len <= l;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		if (w == 2'h1) repeat (202) @(posedge clk);
		repeat (2) @(posedge clk);
		chk("reset on", 0, chipResetN);
		relWait(1'b1);
	endtask : srcHit

	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, kick} = 7'h00;
		{awaddr, araddr, wdata, which, len, go, tickOn} = 56'h0;
		{alwaysOnFuse, bandgap, adcEn} = 3'h0;
		fuse = 3'h7;
		void'($urandom(32'hFBA9D570));
		dly = 16'($urandom_range(40, 8));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (dly + 10) @(posedge clk);
		ctl(32'h00);
		rdt(4'hC);
		chk("unmapped data", 0, rd);
		chk("unmapped resp", RESP_SLVERR, rsp);
		wr(4'hC, 32'h00);
		chk("bresp bad", RESP_SLVERR, bsp);
		wr(CTRL_ADDR, 32'h08);
		chk("bresp ok", RESP_OKAY, bsp);
		ctl(32'h08);
		wr(CTRL_ADDR, 32'h00);
		ctl(32'h08);
		mSel = $urandom_range(7);
		wr(CTRL_ADDR, 32'h18);
		wr(CTRL_ADDR, mSel);
		ctl(mSel);
		wr(CTRL_ADDR, 32'h18);
		repeat (8) @(posedge clk);
		wr(CTRL_ADDR, 32'h03);
		ctl(32'h08 | mSel);
		srcHit(2'h0, 12'd20);
		ctl(32'h00);
		dly <= 16'($urandom_range(60, 1));
		srcHit(2'h2, 12'd10);
		fuse <= 3'h3;
		srcHit(2'h1, 12'd260);
		which <= 2'h1;
		len <= 12'($urandom_range(150, 1));
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		repeat (220) begin
			@(posedge clk);
			if (chipResetN !== 1'b1) n++;
		end
		chk("short dip", 0, n);
		alwaysOnFuse <= 1'b1;
		srcHit(2'h0, 12'd20);
		ctl(32'h08);
		wr(CTRL_ADDR, 32'h00);
		ctl(32'h08);
		for (int i = 0; i < 2; i++) begin
			wr(CTRL_ADDR, 32'h18);
			wr(CTRL_ADDR, 32'h06 * (1 - i));
			ctl(32'h08 | 32'h06 * (1 - i));
		end
		// Enabled but without oscillator ticks: must never expire
		repeat (17000) @(posedge clk);
		chk("tickless", 0, dogCnt);
		tickOn <= 1'b1;
		repeat (3) begin
			repeat (10000) @(posedge clk);
			kick <= 1'b1;
			@(posedge clk);
			kick <= 1'b0;
		end
		chk("kicked", 0, dogCnt);
		n = 0;
		while (dogResetPulse !== 1'b1 && n < 17000) begin
			@(posedge clk);
			n++;
		end
		m = (n >= 16382 && n <= 16388) ? 16384 : n;
		chk("period", 16384, m);
		tickOn <= 1'b0;
		@(posedge clk);
		chk("pulse", 0, {dogResetPulse, chipResetN});
		relWait(1'b0);
		rdt(STAT_ADDR);
		chk("flag", 32'h08, rd);
		wr(STAT_ADDR, 32'h00);
		rdt(STAT_ADDR);
		chk("flag clr", 32'h00, rd);
		for (int i = 0; i < 8; i++) begin
			fuse <= i[0] ? 3'h3 : 3'h7;
			bandgap <= i[1];
			adcEn <= i[2];
			repeat (3) @(posedge clk);
			chk("ref", i != 0, refEnable);
		end
		final_report();
	end
endmodule : reset_sources_and_watchdog_test
